// ===== core/msr_responder.sv
// Added by the designer: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "msr_defs.svh"

// Byte FIFO between the list builder and the data-in output stage.
module msr_fifo
	import msr_pkg::*;
#(
	parameter int WIDTH = 9,
	parameter int DEPTH = 8
)
(
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Fill side.
	input wire logic i_in_valid,
	input wire logic [WIDTH-1:0] i_in_data,
	output logic o_in_ready,
	// Drain side.
	output logic o_out_valid,
	output logic [WIDTH-1:0] o_out_data,
	input wire logic i_out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic push;
	logic pop;

	assign o_in_ready = (count_reg != (AW+1)'(DEPTH));
	assign o_out_valid = (count_reg != '0);
	assign o_out_data = mem[rd_ptr_reg];
	assign push = i_in_valid && o_in_ready;
	assign pop = o_out_valid && i_out_ready;

	always_ff @(posedge i_clk)
	begin
		if (push)
			mem[wr_ptr_reg] <= i_in_data;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			if (pop)
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// Mode sense parameter list builder with an AXI4-Lite register slave.
module msr_responder
	import msr_pkg::*;
(
	// Clock and reset.
	input wire logic I_MCLK,
	input wire logic I_NRST,
	// Command from the protocol engine.
	input wire logic I_CMD_VALID,
	input wire msr_cmd_s I_CMD,
	input wire logic I_BUS_RESET,
	output logic O_CMD_READY,
	output logic O_DONE,
	output logic O_PAGE_ABSENT,
	// Data-in byte stream.
	output logic O_DIN_VALID,
	output msr_byte_s O_DIN,
	input wire logic I_DIN_READY,
	// AXI4-Lite slave.
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY
);
	logic [1:0] rst_sync_reg;
	logic rst_n;
	msr_state_e state_reg;
	msr_cmd_s cmd_reg;
	logic [7:0] idx_reg;
	logic [7:0] lastlen_reg;
	logic cur_valid_reg;
	logic sav_valid_reg;
	logic [31:0] cur_reg [`MSR_WORDS];
	logic [31:0] sav_reg [`MSR_WORDS];
	logic has_eaa;
	logic has_tg;
	logic [7:0] total;
	logic [7:0] limit;
	logic [7:0] push_data;
	logic push_last;
	logic push;
	logic fifo_in_ready;
	logic fifo_out_valid;
	msr_byte_s fifo_out;
	logic fifo_pop;
	logic cmd_take;
	logic [7:0] aw_addr_reg;
	logic aw_held_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic w_held_reg;
	logic wr_fire;
	logic wr_hit;
	logic [3:0] ctrl_pulse;

	always_ff @(posedge I_MCLK or negedge I_NRST)
	begin
		if (!I_NRST)
			rst_sync_reg <= 2'b00;
		else
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
	end
	assign rst_n = rst_sync_reg[1];

	// Field value for stored element field m under the requested page control.
	function automatic logic [15:0] field_val(input logic [2:0] m);
		logic [31:0] dw;
		logic [31:0] sel;
		dw = 32'h0;
		case (m[2:1])
			2'd0: dw = `MSR_DEF_W0;
			2'd1: dw = `MSR_DEF_W1;
			2'd2: dw = `MSR_DEF_W2;
			default: dw = `MSR_DEF_W3;
		endcase
		case (cmd_reg.page_control)
			MSR_PC_CURRENT: sel = cur_valid_reg ? cur_reg[m[2:1]] :
				(sav_valid_reg ? sav_reg[m[2:1]] : dw);
			MSR_PC_CHANGEABLE: sel = {`MSR_CHG_FIELD, `MSR_CHG_FIELD};
			MSR_PC_DEFAULT: sel = dw;
			MSR_PC_SAVED: sel = sav_valid_reg ? sav_reg[m[2:1]] : dw;
			default: sel = dw;
		endcase
		return m[0] ? sel[31:16] : sel[15:0];
	endfunction

	// Page selection; the block descriptor flag is never consulted.
	assign has_eaa = (cmd_reg.page_code == `MSR_PG_EAA) || (cmd_reg.page_code == `MSR_PG_ALL);
	assign has_tg = (cmd_reg.page_code == `MSR_PG_TG) || (cmd_reg.page_code == `MSR_PG_ALL);
	assign total = `MSR_HDR_LEN + (has_eaa ? `MSR_EAA_LEN : 8'h00) + (has_tg ? `MSR_TG_LEN : 8'h00);
	assign limit = (cmd_reg.alloc_len < total) ? cmd_reg.alloc_len : total;

	// List byte at position idx_reg: header, element page, then geometry page.
	always_comb
	begin
		logic [7:0] rel;
		logic [15:0] fv;
		logic [2:0] k;
		rel = 8'h00;
		fv = 16'h0000;
		k = 3'd0;
		push_data = 8'h00;
		if (idx_reg == 8'h00)
			push_data = total - `MSR_HDR_LEN;
		else if (idx_reg < `MSR_HDR_LEN)
			push_data = 8'h00;
		else if (has_eaa && (idx_reg < `MSR_HDR_LEN + `MSR_EAA_LEN))
		begin
			rel = idx_reg - `MSR_HDR_LEN;
			k = 3'((rel - 8'h02) >> 1);
			if (k == 3'd1)
				fv = (cmd_reg.page_control == MSR_PC_CHANGEABLE) ? 16'h0000 : `MSR_XPORT_COUNT;
			else if (k == 3'd0)
				fv = field_val(3'd0);
			else
				fv = field_val(k - 3'd1);
			if (rel == 8'h00)
				push_data = {1'b1, 1'b0, `MSR_PG_EAA};
			else if (rel == 8'h01)
				push_data = `MSR_EAA_PLL;
			else if (rel < 8'h12)
				push_data = rel[0] ? fv[7:0] : fv[15:8];
			else
				push_data = 8'h00;
		end
		else
		begin
			rel = idx_reg - (has_eaa ? `MSR_HDR_LEN + `MSR_EAA_LEN : `MSR_HDR_LEN);
			if (rel == 8'h00)
				push_data = {1'b0, 1'b0, `MSR_PG_TG};
			else if (rel == 8'h01)
				push_data = `MSR_TG_PLL;
			else
				push_data = 8'h00;
		end
	end

	assign cmd_take = I_CMD_VALID && O_CMD_READY;
	assign push = (state_reg == MSR_ST_EMIT) && fifo_in_ready;
	assign push_last = (idx_reg == limit - 8'h01);

	always_ff @(posedge I_MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= MSR_ST_IDLE;
			cmd_reg <= '0;
			idx_reg <= 8'h00;
			O_CMD_READY <= 1'b0;
			O_DONE <= 1'b0;
			O_PAGE_ABSENT <= 1'b0;
			lastlen_reg <= 8'h00;
		end
		else
		begin
			O_DONE <= 1'b0;
			case (state_reg)
				MSR_ST_IDLE:
				begin
					O_CMD_READY <= 1'b1;
					if (cmd_take)
					begin
						cmd_reg <= I_CMD;
						idx_reg <= 8'h00;
						O_CMD_READY <= 1'b0;
						O_PAGE_ABSENT <= (I_CMD.page_code != `MSR_PG_EAA) &&
							(I_CMD.page_code != `MSR_PG_TG) && (I_CMD.page_code != `MSR_PG_ALL);
						state_reg <= (I_CMD.alloc_len == 8'h00) ? MSR_ST_DONE : MSR_ST_EMIT;
					end
				end
				MSR_ST_EMIT:
				begin
					if (push)
					begin
						idx_reg <= idx_reg + 8'h01;
						if (push_last)
							state_reg <= MSR_ST_DONE;
					end
				end
				MSR_ST_DONE:
				begin
					O_DONE <= 1'b1;
					lastlen_reg <= (cmd_reg.alloc_len == 8'h00) ? 8'h00 : limit;
					state_reg <= MSR_ST_IDLE;
				end
				default: state_reg <= MSR_ST_IDLE;
			endcase
		end
	end

	msr_fifo #(.WIDTH(9), .DEPTH(`MSR_FIFO_DEPTH)) u_fifo
	(
		.i_clk(I_MCLK),
		.i_rst_n(rst_n),
		.i_in_valid(push),
		.i_in_data({push_last, push_data}),
		.o_in_ready(fifo_in_ready),
		.o_out_valid(fifo_out_valid),
		.o_out_data(fifo_out),
		.i_out_ready(fifo_pop)
	);

	// Output register stage so the stream ports come from flip-flops.
	assign fifo_pop = !O_DIN_VALID || I_DIN_READY;
	always_ff @(posedge I_MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			O_DIN_VALID <= 1'b0;
			O_DIN <= '0;
		end
		else if (fifo_pop)
		begin
			O_DIN_VALID <= fifo_out_valid;
			O_DIN <= fifo_out;
		end
	end

	// AXI4-Lite write path: address and data taken in either order.
	assign wr_fire = aw_held_reg && w_held_reg && !S_AXI_BVALID;
	assign wr_hit = (aw_addr_reg == `MSR_OFF_CTRL) ||
		((aw_addr_reg[7:4] == `MSR_OFF_CUR0 >> 4) || (aw_addr_reg[7:4] == `MSR_OFF_SAV0 >> 4));
	assign ctrl_pulse = (wr_fire && aw_addr_reg == `MSR_OFF_CTRL && w_strb_reg[0]) ?
		w_data_reg[3:0] : 4'h0;

	always_ff @(posedge I_MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0;
			w_strb_reg <= 4'h0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= `MSR_RESP_OKAY;
		end
		else
		begin
			S_AXI_AWREADY <= !aw_held_reg && !(S_AXI_AWVALID && S_AXI_AWREADY);
			S_AXI_WREADY <= !w_held_reg && !(S_AXI_WVALID && S_AXI_WREADY);
			if (S_AXI_AWVALID && S_AXI_AWREADY)
			begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= {S_AXI_AWADDR[7:2], 2'b00};
			end
			if (S_AXI_WVALID && S_AXI_WREADY)
			begin
				w_held_reg <= 1'b1;
				w_data_reg <= S_AXI_WDATA;
				w_strb_reg <= S_AXI_WSTRB;
			end
			if (wr_fire)
			begin
				aw_held_reg <= 1'b0;
				w_held_reg <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= wr_hit ? `MSR_RESP_OKAY : `MSR_RESP_SLVERR;
			end
			else if (S_AXI_BVALID && S_AXI_BREADY)
				S_AXI_BVALID <= 1'b0;
		end
	end

	// Stored parameter words, written by firmware after a mode select or save.
	for (genvar g = 0; g < `MSR_WORDS; g++)
	begin : g_word
		always_ff @(posedge I_MCLK or negedge rst_n)
		begin
			if (!rst_n)
			begin
				cur_reg[g] <= 32'h0;
				sav_reg[g] <= 32'h0;
			end
			else if (wr_fire)
			begin
				for (int b = 0; b < 4; b++)
				begin
					if (w_strb_reg[b] && aw_addr_reg == `MSR_OFF_CUR0 + 8'(4 * g))
						cur_reg[g][8*b +: 8] <= w_data_reg[8*b +: 8];
					if (w_strb_reg[b] && aw_addr_reg == `MSR_OFF_SAV0 + 8'(4 * g))
						sav_reg[g][8*b +: 8] <= w_data_reg[8*b +: 8];
				end
			end
		end
	end

	// Validity of current and saved sets; a set wins over a bus reset clear.
	always_ff @(posedge I_MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cur_valid_reg <= 1'b0;
			sav_valid_reg <= 1'b0;
		end
		else
		begin
			if (ctrl_pulse[`MSR_CTRL_SET_CUR])
				cur_valid_reg <= 1'b1;
			else if (I_BUS_RESET || ctrl_pulse[`MSR_CTRL_CLR_CUR])
				cur_valid_reg <= 1'b0;
			if (ctrl_pulse[`MSR_CTRL_SET_SAV])
				sav_valid_reg <= 1'b1;
		end
	end

	// AXI4-Lite read path.
	always_ff @(posedge I_MCLK or negedge rst_n)
	begin
		if (!rst_n)
		begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0;
			S_AXI_RRESP <= `MSR_RESP_OKAY;
		end
		else
		begin
			S_AXI_ARREADY <= !S_AXI_RVALID && !(S_AXI_ARVALID && S_AXI_ARREADY);
			if (S_AXI_ARVALID && S_AXI_ARREADY)
			begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RRESP <= `MSR_RESP_OKAY;
				S_AXI_RDATA <= 32'h0;
				case ({S_AXI_ARADDR[7:2], 2'b00})
					`MSR_OFF_STATUS: S_AXI_RDATA <= {28'h0, state_reg, sav_valid_reg, cur_valid_reg};
					`MSR_OFF_CTRL: S_AXI_RDATA <= 32'h0;
					`MSR_OFF_LASTLEN: S_AXI_RDATA <= {24'h0, lastlen_reg};
					8'h10, 8'h14, 8'h18, 8'h1c: S_AXI_RDATA <= cur_reg[S_AXI_ARADDR[3:2]];
					8'h20, 8'h24, 8'h28, 8'h2c: S_AXI_RDATA <= sav_reg[S_AXI_ARADDR[3:2]];
					default: S_AXI_RRESP <= `MSR_RESP_SLVERR;
				endcase
			end
			else if (S_AXI_RVALID && S_AXI_RREADY)
				S_AXI_RVALID <= 1'b0;
		end
	end

	sequence s_final_push;
		push && push_last;
	endsequence
	sequence s_done_pulse;
		(state_reg == MSR_ST_DONE) ##1 O_DONE;
	endsequence

	a_zero_alloc_silent: assert property (@(posedge I_MCLK) disable iff (!rst_n)
		cmd_take && I_CMD.alloc_len == 8'h00 |=> (!push && state_reg == MSR_ST_DONE) ##1 O_DONE)
		else $error("Zero allocation length produced data.");
	a_no_overrun: assert property (@(posedge I_MCLK) disable iff (!rst_n)
		push |-> idx_reg < limit && idx_reg < total)
		else $error("Byte pushed beyond the transfer limit.");
	a_end_at_limit: assert property (@(posedge I_MCLK) disable iff (!rst_n)
		s_final_push |=> s_done_pulse)
		else $error("Transfer did not end after the final byte.");
	a_header_length: assert property (@(posedge I_MCLK) disable iff (!rst_n)
		push && idx_reg == 8'h00 |->
		push_data == (has_eaa ? 8'h14 : 8'h00) + (has_tg ? 8'h04 : 8'h00))
		else $error("Header length byte wrong.");
	a_eaa_code_byte: assert property (@(posedge I_MCLK) disable iff (!rst_n)
		push && has_eaa && idx_reg == 8'h04 |-> push_data == 8'h9d)
		else $error("Element page code byte wrong.");
	a_tg_length_byte: assert property (@(posedge I_MCLK) disable iff (!rst_n)
		push && has_tg && idx_reg == (has_eaa ? 8'h19 : 8'h05) |-> push_data == 8'h02)
		else $error("Geometry page length byte wrong.");
	a_ascending_bytes: assert property (@(posedge I_MCLK) disable iff (!rst_n)
		push && !push_last |=> idx_reg == $past(idx_reg) + 8'h01)
		else $error("List bytes not sent in ascending order.");
	a_saved_fallback: assert property (@(posedge I_MCLK) disable iff (!rst_n)
		push && has_eaa && idx_reg == 8'h0b && cmd_reg.page_control == MSR_PC_SAVED
		&& !sav_valid_reg |-> push_data == 8'(`MSR_DEF_W0 >> 16))
		else $error("Saved request without saved set did not return default.");
	a_changeable_count: assert property (@(posedge I_MCLK) disable iff (!rst_n)
		push && has_eaa && idx_reg == 8'h09 && cmd_reg.page_control == MSR_PC_CHANGEABLE
		|-> push_data == 8'h00)
		else $error("Fixed transport count reported changeable.");
endmodule

// ===== shared/msr_defs.svh
// Notes on behaviour
// - Page control: current, changeable, default, saved.
// - Current uses select, else saved, else default.
// - Changeable sets alterable bits; code, length real.
// - Default returns defaults, unsupported parameters zero.
// - Saved returns saved, else defaults when none.
// - Block descriptor flag ignored, none ever returned.
// - Single page named by page code returned.
// - All-pages code returns pages in ascending order.
// - Zero allocation length transfers no bytes.
// - Stop at smaller of list and allocation.
// - Four-byte header, byte 0 length, pages follow.
// - Element page: savable, code, length eighteen.
// - Element page fields as 16-bit pairs, tail zero.
// - Geometry page: not savable, code, length two.
// - Geometry rotate and member number read zero.
`ifndef MSR_DEFS_SVH
`define MSR_DEFS_SVH

// Register byte addresses.
`define MSR_OFF_STATUS 8'h00
`define MSR_OFF_CTRL 8'h04
`define MSR_OFF_LASTLEN 8'h08
`define MSR_OFF_CUR0 8'h10
`define MSR_OFF_SAV0 8'h20
`define MSR_WORDS 4

// Control register bit positions.
`define MSR_CTRL_SET_CUR 0
`define MSR_CTRL_SET_SAV 1
`define MSR_CTRL_CLR_CUR 2

// Default element field words, two 16-bit fields per word, low field first.
`define MSR_DEF_W0 32'h0001_0000
`define MSR_DEF_W1 32'h0100_000a
`define MSR_DEF_W2 32'h0200_0001
`define MSR_DEF_W3 32'h0000_0002
`define MSR_CHG_FIELD 16'hffff
`define MSR_XPORT_COUNT 16'h0001

// Page codes and layout.
`define MSR_PG_EAA 6'h1d
`define MSR_PG_TG 6'h1e
`define MSR_PG_ALL 6'h3f
`define MSR_HDR_LEN 8'h04
`define MSR_EAA_LEN 8'h14
`define MSR_TG_LEN 8'h04
`define MSR_EAA_PLL 8'h12
`define MSR_TG_PLL 8'h02
`define MSR_FIFO_DEPTH 8

`define MSR_RESP_OKAY 2'b00
`define MSR_RESP_SLVERR 2'b10

`endif

// ===== shared/msr_pkg.sv
package msr_pkg;

	typedef enum logic [1:0]
	{
		MSR_PC_CURRENT = 2'h0,
		MSR_PC_CHANGEABLE = 2'h1,
		MSR_PC_DEFAULT = 2'h2,
		MSR_PC_SAVED = 2'h3
	} msr_pc_e;

	typedef enum logic [1:0]
	{
		MSR_ST_IDLE = 2'b00,
		MSR_ST_EMIT = 2'b01,
		MSR_ST_DONE = 2'b10
	} msr_state_e;

	typedef struct packed
	{
		logic skip_block_descriptors_flag;
		msr_pc_e page_control;
		logic [5:0] page_code;
		logic [7:0] alloc_len;
	} msr_cmd_s;

	typedef struct packed
	{
		logic last;
		logic [7:0] data;
	} msr_byte_s;

endpackage

// ===== tb/msr_sink.sv
`timescale 1ns/1ps

// Data-in sink standing in for the initiator; in slow mode it is ready one cycle in three.
module msr_sink
(
	// Clock and reset.
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Pace and handshake.
	input wire logic i_slow,
	output logic o_ready
);
	logic [1:0] cnt_reg;

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			cnt_reg <= 2'h0;
		else
			cnt_reg <= (cnt_reg == 2'h2) ? 2'h0 : cnt_reg + 2'h1;
	end

	always_ff @(posedge i_clk or negedge i_rst_n)
	begin
		if (!i_rst_n)
			o_ready <= 1'b0;
		else
			o_ready <= !i_slow || (cnt_reg == 2'h0);
	end
endmodule

// ===== tb/msr_responder_bench.sv
`timescale 1ns/1ps
`include "msr_defs.svh"

module msr_responder_bench
	import msr_pkg::*;
;
	logic clk, nrst, cv, brst, cr, dn, pa, dv, dr, slow;
	msr_cmd_s cmd;
	msr_byte_s din;
	logic [7:0] awa, ara;
	logic awv, awr, wv, wr_rdy, bv, bry, arv, arr, rv, rry;
	logic [31:0] wd, rdat, d;
	logic [1:0] bresp, rresp, r;
	logic [7:0] got[$], exp[$];
	logic lastq[$];
	logic [31:0] cur[4], sav[4];
	logic [31:0] dflt[4] = '{`MSR_DEF_W0, `MSR_DEF_W1, `MSR_DEF_W2, `MSR_DEF_W3};
	logic cur_ok, sav_ok;
	int ndone, fails, checks;
	logic [5:0] codes[6] = '{6'h1d, 6'h1e, 6'h1f, 6'h22, 6'h3d, 6'h3e};

	msr_responder u_dut (.I_MCLK(clk), .I_NRST(nrst), .I_CMD_VALID(cv), .I_CMD(cmd),
		.I_BUS_RESET(brst), .O_CMD_READY(cr), .O_DONE(dn), .O_PAGE_ABSENT(pa),
		.O_DIN_VALID(dv), .O_DIN(din), .I_DIN_READY(dr), .S_AXI_AWADDR(awa),
		.S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hf),
		.S_AXI_WVALID(wv), .S_AXI_WREADY(wr_rdy), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bv),
		.S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry));
	msr_sink u_sink (.i_clk(clk), .i_rst_n(nrst), .i_slow(slow), .o_ready(dr));

	initial
	begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	always @(posedge clk)
	begin
		if (dv && dr)
		begin
			got.push_back(din.data);
			lastq.push_back(din.last);
		end
		if (dn)
			ndone++;
	end

	task summarize();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask

	task wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic ad, wdn;
		ad = 1'b0;
		wdn = 1'b0;
		@(posedge clk);
		awa <= a;
		awv <= 1'b1;
		wd <= v;
		wv <= 1'b1;
		bry <= 1'b1;
		forever
		begin
			@(posedge clk);
			if (!ad && awr)
			begin
				ad = 1'b1;
				awv <= 1'b0;
			end
			if (!wdn && wr_rdy)
			begin
				wdn = 1'b1;
				wv <= 1'b0;
			end
			if (bv)
			begin
				rs = bresp;
				bry <= 1'b0;
				break;
			end
		end
	endtask

	task rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		@(posedge clk);
		ara <= a;
		arv <= 1'b1;
		rry <= 1'b1;
		forever
		begin
			@(posedge clk);
			if (arr)
				arv <= 1'b0;
			if (rv)
			begin
				v = rdat;
				rs = rresp;
				rry <= 1'b0;
				break;
			end
		end
	endtask

	// Expected list from the stored words, page control and page code.
	task build(input logic [1:0] pc, input logic [5:0] cd, input logic [7:0] al);
		logic [31:0] w[4];
		logic [15:0] f[8];
		logic ea, tg;
		ea = (cd == `MSR_PG_EAA) || (cd == `MSR_PG_ALL);
		tg = (cd == `MSR_PG_TG) || (cd == `MSR_PG_ALL);
		foreach (w[i])
			w[i] = (pc == 2'h0 && cur_ok) ? cur[i] :
				((pc == 2'h0 || pc == 2'h3) && sav_ok) ? sav[i] : dflt[i];
		f = '{w[0][15:0], 16'h0001, w[0][31:16], w[1][15:0], w[1][31:16], w[2][15:0],
			w[2][31:16], w[3][15:0]};
		if (pc == 2'h1)
		begin
			foreach (f[i])
				f[i] = 16'hffff;
			f[1] = 16'h0000;
		end
		exp = '{8'h00, 8'h00, 8'h00, 8'h00};
		exp[0] = (ea ? 8'h14 : 8'h00) + (tg ? 8'h04 : 8'h00);
		if (ea)
		begin
			exp.push_back(8'h9d);
			exp.push_back(8'h12);
			foreach (f[i])
			begin
				exp.push_back(f[i][15:8]);
				exp.push_back(f[i][7:0]);
			end
			exp.push_back(8'h00);
			exp.push_back(8'h00);
		end
		if (tg)
			exp = {exp, 8'h1e, 8'h02, 8'h00, 8'h00};
		while (exp.size() > al)
			exp.pop_back();
	endtask

	task run(input logic [1:0] pc, input logic [5:0] cd, input logic [7:0] al, input logic db);
		build(pc, cd, al);
		got.delete();
		lastq.delete();
		ndone = 0;
		@(posedge clk);
		cv <= 1'b1;
		cmd <= msr_cmd_s'({db, pc, cd, al});
		do
			@(posedge clk);
		while (!cr);
		cv <= 1'b0;
		while (!(ndone > 0 && got.size() >= exp.size()))
			@(posedge clk);
		repeat (6) @(posedge clk);
		chk("length", got.size(), exp.size());
		foreach (exp[i])
			if (i < got.size())
				chk("byte", got[i], exp[i]);
		if (got.size() > 0)
			chk("last", lastq[$], 1'b1);
		chk("absent", pa, !(cd == 6'h1d || cd == 6'h1e || cd == 6'h3f));
	endtask

	initial
	begin
		#(40 * 60000);
		fails++;
		summarize();
	end

	initial
	begin
		{nrst, cv, brst, slow, awv, wv, bry, arv, rry} = '0;
		cmd = '0;
		awa = '0;
		ara = '0;
		wd = '0;
		cur_ok = 1'b0;
		sav_ok = 1'b0;
		repeat (16) @(posedge clk);
		nrst <= 1'b1;
		repeat (5) @(posedge clk);
		rd(8'h00, d, r);
		chk("status", d[1:0], 2'h0);
		rd(8'h40, d, r);
		chk("rd unmapped", r, `MSR_RESP_SLVERR);
		wr(8'h40, 32'h1, r);
		chk("wr unmapped", r, `MSR_RESP_SLVERR);
		wr(8'h00, 32'h1, r);
		chk("wr status", r, `MSR_RESP_SLVERR);
		for (int p = 0; p < 4; p++)
			run(p[1:0], `MSR_PG_ALL, 8'hff, p[0]);
		foreach (codes[i])
			run(2'h2, codes[i], 8'hff, 1'b0);
		slow <= 1'b1;
		run(2'h0, `MSR_PG_ALL, 8'h00, 1'b0);
		rd(`MSR_OFF_LASTLEN, d, r);
		chk("lastlen", d, 32'h0);
		run(2'h0, `MSR_PG_EAA, 8'h05, 1'b0);
		rd(`MSR_OFF_LASTLEN, d, r);
		chk("lastlen", d, 32'h5);
		run(2'h1, `MSR_PG_ALL, 8'h1b, 1'b1);
		slow <= 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			sav[i] = 32'h5a00_0100 + i * 32'h0101_0011;
			cur[i] = 32'h0a30_7002 + i * 32'h1010_0101;
			wr(8'h20 + 8'(4 * i), sav[i], r);
			wr(8'h10 + 8'(4 * i), cur[i], r);
		end
		rd(8'h10, d, r);
		chk("cur word", d, cur[0]);
		wr(8'h04, 32'h2, r);
		sav_ok = 1'b1;
		run(2'h3, `MSR_PG_ALL, 8'hff, 1'b0);
		run(2'h0, `MSR_PG_ALL, 8'hff, 1'b0);
		run(2'h2, `MSR_PG_EAA, 8'hff, 1'b0);
		wr(8'h04, 32'h1, r);
		cur_ok = 1'b1;
		run(2'h0, `MSR_PG_ALL, 8'hff, 1'b0);
		rd(8'h00, d, r);
		chk("status", d[1:0], 2'h3);
		@(posedge clk);
		brst <= 1'b1;
		@(posedge clk);
		brst <= 1'b0;
		cur_ok = 1'b0;
		run(2'h0, `MSR_PG_EAA, 8'hff, 1'b0);
		rd(8'h00, d, r);
		chk("status", d[1:0], 2'h2);
		wr(8'h04, 32'h1, r);
		cur_ok = 1'b1;
		run(2'h0, `MSR_PG_EAA, 8'hff, 1'b0);
		wr(8'h04, 32'h4, r);
		cur_ok = 1'b0;
		run(2'h0, `MSR_PG_EAA, 8'hff, 1'b0);
		summarize();
	end
endmodule
